// ==== design/dms_shifter_top.sv ====
/*
 * dms_shifter_top: digit and multi-word bit shifter with its own
 * operand word store, digit shift register and error flags.
 * Assumes: the sequencer raises opStart for one cycle while idle and
 * keeps shift counts within 0 to 16; one clock, asynchronous reset.
 */
`timescale 1ns/1ps
// How it works
// - digit right shift moves the operand word down by one nibble.
// - right shift puts expelled bits 3..0 in digit register low nibble.
// - right shift clears operand bits 15..12.
// - digit left shift moves the operand word up by one nibble.
// - left shift puts expelled bits 15..12 in digit register low nibble.
// - left shift clears operand bits 3..0.
// - range right shift moves words start..end down by the count.
// - range left shift moves words start..end up by the count.
// - vacated bit positions of a range shift fill with zero.
// - a count of 0 leaves every range word unchanged.
// - a count of 16 shifts the range by one whole word.
// - start above end or count of 16 or more sets the sticky error.
// - the same conditions pulse the momentary error for one cycle.
module dms_shifter_top (
   input  wire logic                     clk,                        // 250 MHz clock
   input  wire logic                     reset_n,                    // async reset
   input  wire logic                     opStart,                    // trigger, one cycle
   input  wire dms_pkg::dms_op_t         opCode,                     // operation
   input  wire logic [dms_pkg::ADDR_W-1:0] operandAddr,              // digit shift word
   input  wire logic [dms_pkg::ADDR_W-1:0] rangeStartWord,           // first range word
   input  wire logic [dms_pkg::ADDR_W-1:0] rangeEndWord,             // last range word
   input  wire logic [dms_pkg::CNT_W-1:0]  shiftCount,               // range shift bits
   input  wire logic                     clearStickyError,           // clears sticky flag
   input  wire logic                     hostWrEn,                   // load word when idle
   input  wire logic [dms_pkg::ADDR_W-1:0] hostAddr,                 // load/read address
   input  wire logic [dms_pkg::WORD_W-1:0] hostWrData,               // load data
   output logic [dms_pkg::WORD_W-1:0]    hostRdData_r,               // word at hostAddr
   output logic [dms_pkg::WORD_W-1:0]    digit_shift_register_r,     // digit shift register
   output logic                          sticky_operation_error_flag_r, // sticky error
   output logic                          momentary_error_flag_r,     // one-cycle error
   output logic                          busy_r,                     // operation in flight
   output logic                          done_r                      // one-cycle finish
);
   import dms_pkg::*;

   dms_state_t         state_r;
   logic [WORD_W-1:0]  mem [DEPTH];
   logic [ADDR_W-1:0]  idx_r;
   logic [ADDR_W-1:0]  firstHold_r;
   logic [ADDR_W-1:0]  lastHold_r;
   logic [CNT_W-1:0]   countHold_r;
   logic               dirLeft_r;
   logic               isDigit;
   logic               isRange;
   logic               startErr;
   logic               walkOk;
   logic               lastStep;
   logic [DIGIT_W+WORD_W-1:0] digitRes;
   dms_slice_if        sliceIf ();

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   assign isDigit  = (state_r == ST_IDLE) && opStart && !opCode[1];
   assign isRange  = (state_r == ST_IDLE) && opStart && opCode[1];
   assign startErr = range_error(rangeStartWord, rangeEndWord, shiftCount);
   // a count of 16 is an error yet still walks; only worse requests are dropped
   assign walkOk   = (rangeStartWord <= rangeEndWord) && (shiftCount <= COUNT_WORD);
   assign digitRes = digit_shift(mem[operandAddr], opCode[0]);
   assign lastStep = dirLeft_r ? (idx_r == firstHold_r) : (idx_r == lastHold_r);

   // ---------------------------------------------------------------
   // word slice feed
   // ---------------------------------------------------------------
   // right walks upward, left walks downward, so the neighbour is still old
   assign sliceIf.cur     = mem[idx_r];
   assign sliceIf.nbr     = lastStep ? WORD_RESET :
                            (dirLeft_r ? mem[idx_r - 1'b1] : mem[idx_r + 1'b1]);
   assign sliceIf.count   = countHold_r;
   assign sliceIf.dirLeft = dirLeft_r;

   dms_word_slice uSlice (
      .slc (sliceIf.calc)
   );

   // ---------------------------------------------------------------
   // controller
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r     <= ST_IDLE;
         idx_r       <= '0;
         firstHold_r <= '0;
         lastHold_r  <= '0;
         countHold_r <= '0;
         dirLeft_r   <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (isRange && walkOk) begin
                  state_r     <= ST_RUN;
                  firstHold_r <= rangeStartWord;
                  lastHold_r  <= rangeEndWord;
                  countHold_r <= shiftCount;
                  dirLeft_r   <= opCode[0];
                  idx_r       <= opCode[0] ? rangeEndWord : rangeStartWord;
               end else if (opStart) begin
                  state_r <= ST_DONE;   // digit ops and refused ranges end at once
               end
            end
            ST_RUN: begin
               if (lastStep)
                  state_r <= ST_DONE;
               else
                  idx_r <= dirLeft_r ? idx_r - 1'b1 : idx_r + 1'b1;
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // operand word store
   // ---------------------------------------------------------------
   // host loads are ignored while an operation owns the store
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= WORD_RESET;
      end else if (isDigit) begin
         mem[operandAddr] <= digitRes[WORD_W-1:0];
      end else if (state_r == ST_RUN) begin
         mem[idx_r] <= sliceIf.result;
      end else if (hostWrEn && state_r == ST_IDLE && !opStart) begin
         mem[hostAddr] <= hostWrData;
      end
   end

   // ---------------------------------------------------------------
   // digit shift register, status and readback
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         digit_shift_register_r <= DSR_RESET;
      else if (isDigit)
         digit_shift_register_r[DIGIT_W-1:0] <= digitRes[DIGIT_W+WORD_W-1:WORD_W];
   end

   // error flags: a new error wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sticky_operation_error_flag_r <= 1'b0;
         momentary_error_flag_r        <= 1'b0;
      end else begin
         momentary_error_flag_r <= isRange && startErr;
         if (isRange && startErr)
            sticky_operation_error_flag_r <= 1'b1;
         else if (clearStickyError)
            sticky_operation_error_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_r       <= 1'b0;
         done_r       <= 1'b0;
         hostRdData_r <= WORD_RESET;
      end else begin
         // a walk raises done only after its last word, never at launch
         busy_r       <= (state_r == ST_IDLE) ? (isRange && walkOk)
                                              : (state_r == ST_RUN && !lastStep);
         done_r       <= (state_r == ST_IDLE) ? (opStart && !(isRange && walkOk))
                                              : (state_r == ST_RUN && lastStep);
         hostRdData_r <= mem[hostAddr];
      end
   end

   // ---------------------------------------------------------------
   // assertions and covers
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] prevWord_h;
   logic [ADDR_W-1:0] prevAddr_h;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prevWord_h <= WORD_RESET;
         prevAddr_h <= '0;
      end else begin
         prevWord_h <= mem[operandAddr];
         prevAddr_h <= operandAddr;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_digit_right_word: assert property (
      isDigit && opCode == DIGIT_SHIFT_RIGHT_OP |=> mem[prevAddr_h] == {4'h0, prevWord_h[15:4]})
      else $error("digit right shift gave wrong word");
   a_digit_right_reg: assert property (
      isDigit && opCode == DIGIT_SHIFT_RIGHT_OP |=> digit_shift_register_r[3:0] == prevWord_h[3:0])
      else $error("digit right shift lost expelled nibble");
   a_digit_left_word: assert property (
      isDigit && opCode == DIGIT_SHIFT_LEFT_OP |=> mem[prevAddr_h] == {prevWord_h[11:0], 4'h0})
      else $error("digit left shift gave wrong word");
   a_digit_left_reg: assert property (
      isDigit && opCode == DIGIT_SHIFT_LEFT_OP |=> digit_shift_register_r[3:0] == prevWord_h[15:12])
      else $error("digit left shift lost expelled nibble");
   a_range_zero_count: assert property (
      state_r == ST_RUN && countHold_r == 5'h00 |-> sliceIf.result == sliceIf.cur)
      else $error("count zero changed a word");
   a_range_word_count: assert property (
      state_r == ST_RUN && countHold_r == COUNT_WORD |-> sliceIf.result == sliceIf.nbr)
      else $error("count sixteen was not a word shift");
   a_range_zero_fill: assert property (
      state_r == ST_RUN && !dirLeft_r && lastStep && countHold_r != 5'h00
      |-> (sliceIf.result >> (WORD_W - countHold_r)) == 16'h0000)
      else $error("right range shift did not fill zeros");
   a_range_left_fill: assert property (
      state_r == ST_RUN && dirLeft_r && countHold_r == 5'h01
      |-> sliceIf.result == {sliceIf.cur[14:0], sliceIf.nbr[15]})
      else $error("left range shift lost a carried bit");
   a_error_both_flags: assert property (
      isRange && startErr |=> momentary_error_flag_r && sticky_operation_error_flag_r
      ##1 !momentary_error_flag_r)
      else $error("error flags not raised as expected");
   a_sticky_holds: assert property (
      sticky_operation_error_flag_r && !clearStickyError |=> sticky_operation_error_flag_r)
      else $error("sticky error dropped by itself");
   a_range_finishes: assert property (
      isRange && walkOk |-> ##[2:17] done_r)
      else $error("range shift did not finish in time");

   c_digit_right: cover property (isDigit && opCode == DIGIT_SHIFT_RIGHT_OP);
   c_digit_left:  cover property (isDigit && opCode == DIGIT_SHIFT_LEFT_OP);
   c_range_done:  cover property (state_r == ST_RUN && lastStep && lastHold_r != firstHold_r);
   c_word_shift:  cover property (isRange && shiftCount == COUNT_WORD);

endmodule // dms_shifter_top

// ==== design/dms_pkg.sv ====
/*
 * dms_pkg: shared widths, opcodes, states, reset values and helper
 * functions of the digit and multi-word bit shifter.
 * Assumes: imported by the shifter top, its word slice and its interface.
 */
package dms_pkg;

   // ---------------------------------------------------------------
   // widths and sizes
   // ---------------------------------------------------------------
   localparam int WORD_W    = 16;              // operand word width
   localparam int DIGIT_W   = 4;               // one hex digit
   localparam int ADDR_W    = 4;               // operand word address width
   localparam int DEPTH     = 16;              // operand words held
   localparam int CNT_W     = 5;               // shift count width

   localparam logic [CNT_W-1:0]  COUNT_WORD = 5'h10;   // count meaning one whole word
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000; // operand words after reset
   localparam logic [WORD_W-1:0] DSR_RESET  = 16'h0000; // digit shift register reset

   // ---------------------------------------------------------------
   // operations and controller states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DIGIT_SHIFT_RIGHT_OP     = 2'h0,
      DIGIT_SHIFT_LEFT_OP      = 2'h1,
      RANGE_BIT_SHIFT_RIGHT_OP = 2'h2,
      RANGE_BIT_SHIFT_LEFT_OP  = 2'h3
   } dms_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RUN  = 3'h2,
      ST_DONE = 3'h4
   } dms_state_t;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // range request is in error when start is past end or count reaches a word
   function automatic logic range_error(input logic [ADDR_W-1:0] first,
                                        input logic [ADDR_W-1:0] last,
                                        input logic [CNT_W-1:0]  count);
      return (first > last) || (count >= COUNT_WORD);
   endfunction

   // one-digit shift: returns {expelled digit, shifted word}
   function automatic logic [DIGIT_W+WORD_W-1:0] digit_shift(input logic [WORD_W-1:0] w,
                                                             input logic toLeft);
      if (toLeft)
         return {w[15:12], w[11:0], 4'h0};
      return {w[3:0], 4'h0, w[15:4]};
   endfunction

endpackage

// ==== design/dms_slice_if.sv ====
/*
 * dms_slice_if: carries one word, its neighbour and the shift request
 * to the word slice, and the shifted word back.
 * Assumes: driven by the shifter top, combinational only.
 */
`timescale 1ns/1ps
interface dms_slice_if;
   import dms_pkg::*;
   logic [WORD_W-1:0] cur;      // word being rewritten
   logic [WORD_W-1:0] nbr;      // neighbour feeding bits in, zero at the range edge
   logic [CNT_W-1:0]  count;    // bits to shift, 0 to 16
   logic              dirLeft;  // 1 toward higher bits
   logic [WORD_W-1:0] result;   // new value of cur

   modport calc (input cur, input nbr, input count, input dirLeft, output result);
   modport user (output cur, output nbr, output count, output dirLeft, input result);
endinterface // dms_slice_if

// ==== design/dms_word_slice.sv ====
/*
 * dms_word_slice: shifts one word of a range, pulling bits in from its
 * neighbour so the range acts as one bit field.
 * Assumes: count never above 16; caller supplies zero as neighbour at the edge.
 */
`timescale 1ns/1ps
module dms_word_slice (
   dms_slice_if.calc slc   // word, neighbour and count in, result out
);
   import dms_pkg::*;

   logic [2*WORD_W-1:0] wide;

   // ---------------------------------------------------------------
   // two-word funnel shift
   // ---------------------------------------------------------------
   // a count of 16 moves the neighbour in whole, which is the word shift
   always_comb begin
      wide = '0;
      if (slc.dirLeft) begin
         wide       = {slc.cur, slc.nbr} << slc.count;
         slc.result = wide[2*WORD_W-1:WORD_W];
      end else begin
         wide       = {slc.nbr, slc.cur} >> slc.count;
         slc.result = wide[WORD_W-1:0];
      end
   end

endmodule // dms_word_slice

// ==== tb/dms_seq_model.sv ====
/*
 * dms_seq_model: stand-in for the instruction sequencer; it turns a
 * one-cycle bench request into a one-cycle opStart carrying the operands.
 * Assumes: the bench requests only while the shifter is idle.
 */
`timescale 1ns/1ps
module dms_seq_model (
   input  wire logic                       clk,            // shifter clock
   input  wire logic                       reset_n,        // async reset, active low
   input  wire logic                       reqGo,          // bench request pulse
   input  wire dms_pkg::dms_op_t           reqOp,          // requested operation
   input  wire logic [dms_pkg::ADDR_W-1:0] reqAddr,        // digit word or range start
   input  wire logic [dms_pkg::ADDR_W-1:0] reqEnd,         // range end
   input  wire logic [dms_pkg::CNT_W-1:0]  reqCount,       // shift bits
   output logic                            opStart,        // trigger to the shifter
   output dms_pkg::dms_op_t                opCode,         // operation to the shifter
   output logic [dms_pkg::ADDR_W-1:0]      operandAddr,    // digit word
   output logic [dms_pkg::ADDR_W-1:0]      rangeStartWord, // first range word
   output logic [dms_pkg::ADDR_W-1:0]      rangeEndWord,   // last range word
   output logic [dms_pkg::CNT_W-1:0]       shiftCount      // range shift bits
);
   import dms_pkg::*;
   // ---------------------------------------------------------------
   // request launch
   // ---------------------------------------------------------------
   // operands are valid only with opStart; released ones churn so stale
   // values can never pass for a request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opStart        <= 1'h0;
         opCode         <= DIGIT_SHIFT_RIGHT_OP;
         operandAddr    <= 4'h0;
         rangeStartWord <= 4'h0;
         rangeEndWord   <= 4'h0;
         shiftCount     <= 5'h00;
      end else begin
         opStart <= reqGo;
         if (reqGo) begin
            opCode         <= reqOp;
            operandAddr    <= reqAddr;
            rangeStartWord <= reqAddr;
            rangeEndWord   <= reqEnd;
            shiftCount     <= reqCount;
         end else begin
            opCode         <= dms_op_t'(~opCode);
            operandAddr    <= ~operandAddr;
            rangeStartWord <= ~rangeStartWord;
            rangeEndWord   <= ~rangeEndWord;
            shiftCount     <= ~shiftCount;
         end
      end
   end
endmodule // dms_seq_model

// ==== tb/test_digit_and_multiword_bit_shifter.sv ====
/*
 * test_digit_and_multiword_bit_shifter: self-checking bench for the shifter.
 * Assumes: store words are loaded and read back through the host ports.
 */
`timescale 1ns/1ps
module test_digit_and_multiword_bit_shifter;
   import dms_pkg::*;
   logic clk = 1'h0, reset_n = 1'h0, reqGo = 1'h0, clearStickyError = 1'h0, hostWrEn = 1'h0;
   logic opStart, sticky, mom, busy_r, done_r, momSeen, stickyExp = 1'h0;
   dms_op_t reqOp = DIGIT_SHIFT_RIGHT_OP, opCode;
   logic [ADDR_W-1:0] reqAddr = 4'h0, reqEnd = 4'h0, hostAddr = 4'h0;
   logic [ADDR_W-1:0] operandAddr, rangeStartWord, rangeEndWord;
   logic [CNT_W-1:0]  reqCount = 5'h00, shiftCount;
   logic [WORD_W-1:0] hostWrData = 16'h0000, hostRdData_r, dsr, mirror[DEPTH];
   int n_fail = 0, samples_checked = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   dms_seq_model i_dms_seq_model (.clk(clk), .reset_n(reset_n), .reqGo(reqGo), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqEnd(reqEnd), .reqCount(reqCount), .opStart(opStart),
      .opCode(opCode), .operandAddr(operandAddr), .rangeStartWord(rangeStartWord),
      .rangeEndWord(rangeEndWord), .shiftCount(shiftCount));
   dms_shifter_top i_dms_shifter_top (.clk(clk), .reset_n(reset_n), .opStart(opStart),
      .opCode(opCode), .operandAddr(operandAddr), .rangeStartWord(rangeStartWord),
      .rangeEndWord(rangeEndWord), .shiftCount(shiftCount),
      .clearStickyError(clearStickyError), .hostWrEn(hostWrEn), .hostAddr(hostAddr),
      .hostWrData(hostWrData), .hostRdData_r(hostRdData_r), .digit_shift_register_r(dsr),
      .sticky_operation_error_flag_r(sticky), .momentary_error_flag_r(mom),
      .busy_r(busy_r), .done_r(done_r));

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic give_verdict;
      if (n_fail == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [WORD_W-1:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic host_wr(input int a, input logic [WORD_W-1:0] d);
      @(posedge clk);
      hostWrEn   <= 1'h1;
      hostAddr   <= a[3:0];
      hostWrData <= d;
      @(posedge clk);
      hostWrEn <= 1'h0;
      mirror[a] = d;
   endtask

   // whole store compared, so words outside a range are checked untouched too
   task automatic check_store;
      for (int k = 0; k < DEPTH; k++) begin
         @(posedge clk);
         hostAddr <= k[3:0];
         @(posedge clk);
         @(posedge clk);
         #1 chk("store word", hostRdData_r, mirror[k]);
      end
   endtask

   // bounded wait for done; a hang ends the run as a failure
   task automatic run_op(input dms_op_t o, input int a, e, n);
      int i;
      logic walk;
      walk = (o inside {RANGE_BIT_SHIFT_RIGHT_OP, RANGE_BIT_SHIFT_LEFT_OP}) && a <= e && n <= 16;
      @(posedge clk);
      reqGo    <= 1'h1;
      reqOp    <= o;
      reqAddr  <= a[3:0];
      reqEnd   <= e[3:0];
      reqCount <= n[4:0];
      @(posedge clk);
      reqGo   <= 1'h0;
      momSeen = 1'h0;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         #1 if (mom === 1'h1) momSeen = 1'h1;
         if (i == 0) chk("busy", {15'h0000, busy_r}, {15'h0000, walk});
         if (done_r === 1'h1) break;
      end
      if (i == 40) begin
         n_fail++;
         give_verdict();
      end
      // one word per cycle for a walk, done at once otherwise
      chk("done cycles", 16'(i), walk ? 16'(e - a + 1) : 16'h0000);
   endtask

   task automatic digit_case(input dms_op_t o, input int a, input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] dExp;
      host_wr(a, w);
      run_op(o, a, 0, 0);
      mirror[a] = (o == DIGIT_SHIFT_LEFT_OP) ? {w[11:0], 4'h0} : {4'h0, w[15:4]};
      dExp = (o == DIGIT_SHIFT_LEFT_OP) ? {12'h000, w[15:12]} : {12'h000, w[3:0]};
      chk("digit register", dsr, dExp);
      check_store();
   endtask

   // expected words: range is one field, higher address more significant
   task automatic range_case(input dms_op_t o, input int s, e, n);
      logic [WORD_W-1:0] old[DEPTH];
      logic err;
      old = mirror;
      err = (s > e) || (n >= 16);
      if (s <= e && n <= 16)
         for (int k = s; k <= e; k++)
            mirror[k] = (o == RANGE_BIT_SHIFT_RIGHT_OP)
               ? 16'({(k == e) ? 16'h0000 : old[k+1], old[k]} >> n)
               : 16'(({old[k], (k == s) ? 16'h0000 : old[k-1]} << n) >> 16);
      stickyExp |= err;
      run_op(o, s, e, n);
      chk("momentary error", {15'h0000, momSeen}, {15'h0000, err});
      chk("sticky error", {15'h0000, sticky}, {15'h0000, stickyExp});
      check_store();
   endtask

   task automatic clear_sticky;
      @(posedge clk);
      clearStickyError <= 1'h1;
      @(posedge clk);
      clearStickyError <= 1'h0;
      @(posedge clk);
      #1 chk("sticky cleared", {15'h0000, sticky}, 16'h0000);
      stickyExp = 1'h0;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      #1 chk("digit register reset", dsr, 16'h0000);
      chk("flags reset", {11'h000, sticky, mom, busy_r, done_r, 1'h0}, 16'h0000);
      for (int k = 0; k < DEPTH; k++) mirror[k] = 16'h0000;
      check_store();
   endtask

   // right, left, then right again on the same word at once
   task automatic test_digit;
      digit_case(DIGIT_SHIFT_RIGHT_OP, 2, 16'h1234);
      digit_case(DIGIT_SHIFT_LEFT_OP, 5, 16'hABCD);
      digit_case(DIGIT_SHIFT_RIGHT_OP, 5, 16'hF00E);
   endtask

   task automatic test_range;
      host_wr(0, 16'h1234);
      host_wr(1, 16'hABCD);
      host_wr(2, 16'h5678);
      host_wr(3, 16'h8001);
      host_wr(7, 16'hC3A5);
      range_case(RANGE_BIT_SHIFT_RIGHT_OP, 0, 2, 4);
      range_case(RANGE_BIT_SHIFT_LEFT_OP, 1, 3, 5);
      range_case(RANGE_BIT_SHIFT_LEFT_OP, 7, 7, 15);
      range_case(RANGE_BIT_SHIFT_RIGHT_OP, 0, 15, 0);
      range_case(RANGE_BIT_SHIFT_LEFT_OP, 0, 15, 0);
   endtask

   // whole-word count shifts and flags, sticky kept over a clean op
   task automatic test_word_count;
      host_wr(4, 16'h1111);
      host_wr(5, 16'h2222);
      host_wr(6, 16'h3333);
      range_case(RANGE_BIT_SHIFT_RIGHT_OP, 4, 6, 16);
      range_case(RANGE_BIT_SHIFT_LEFT_OP, 4, 6, 16);
      range_case(RANGE_BIT_SHIFT_RIGHT_OP, 0, 3, 1);
      range_case(RANGE_BIT_SHIFT_LEFT_OP, 0, 3, 1);
      clear_sticky();
   endtask

   // start past end, and a count beyond a word: flags only
   task automatic test_refused;
      range_case(RANGE_BIT_SHIFT_RIGHT_OP, 3, 1, 4);
      clear_sticky();
      range_case(RANGE_BIT_SHIFT_LEFT_OP, 0, 3, 17);
      clear_sticky();
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'h1;
      test_reset();
      test_digit();
      test_range();
      test_word_count();
      test_refused();
      give_verdict();
   end
endmodule // test_digit_and_multiword_bit_shifter
